/* File: adao_pkg.sv */
`default_nettype none
package adao_pkg;
    // clock and sample timing
    localparam int CLK_HZ = 100_000_000;
    localparam int INT_RATE_SPS = 2460;
    localparam int INT_PERIOD_CYC = CLK_HZ / INT_RATE_SPS;
    localparam int EXT_MIN_HZ = 2000;
    localparam int EXT_MAX_PERIOD_CYC = CLK_HZ / EXT_MIN_HZ;

    // byte addresses on the output-data page
    localparam logic [6:0] OFS_PAGE = 7'h00;
    localparam logic [6:0] OFS_ACC_X_FRAC = 7'h1c;
    localparam logic [6:0] OFS_ACC_X_MAIN = 7'h1e;
    localparam logic [6:0] OFS_ACC_Y_FRAC = 7'h20;
    localparam logic [6:0] OFS_ACC_Y_MAIN = 7'h22;
    localparam logic [6:0] OFS_ACC_Z_FRAC = 7'h24;
    localparam logic [6:0] OFS_ACC_Z_MAIN = 7'h26;
    localparam logic [6:0] OFS_ROT_X_FRAC = 7'h40;
    localparam logic [6:0] OFS_ROT_X_MAIN = 7'h42;
    localparam logic [6:0] OFS_ROT_Y_FRAC = 7'h44;
    localparam logic [6:0] OFS_ROT_Y_MAIN = 7'h46;
    localparam logic [6:0] OFS_ROT_Z_FRAC = 7'h48;
    localparam logic [6:0] OFS_ROT_Z_MAIN = 7'h4a;

    // reset values
    localparam logic [15:0] PAGE_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] OUTPUT_PAGE = 16'h0000;

    // full-scale codes
    localparam logic [31:0] ACC_POS_FS = 32'h57e4_0000;
    localparam logic [31:0] ACC_NEG_FS = 32'ha81c_0000;
    localparam logic [31:0] ROT_POS_FS = 32'h7fff_ffff;
    localparam logic [31:0] ROT_NEG_FS = 32'h8000_0000;

    // rate lsb 0.02 deg/s, angle lsb 720/2^31 deg: code = sum * 2^31 * 0.02 / (1440 * fs)
    // scale carries 16 fraction bits, so scale = 2^47 / (72000 * fs)
    localparam int SCALE_SHIFT = 16;
    localparam logic [63:0] SCALE_NUM = 64'h0000_8000_0000_0000;
    localparam logic [63:0] SCALE_DEN = 64'd72000;
    localparam logic [23:0] SCALE_INT = 24'(SCALE_NUM / (SCALE_DEN * 64'(INT_RATE_SPS)));
    // external: scale = period * 2^47 / (72000 * clk_hz), kept with 8 extra fraction bits
    localparam int EXT_FRAC = 8;
    localparam logic [12:0] EXT_SCALE_PER_CYC = 13'((SCALE_NUM << EXT_FRAC) / (SCALE_DEN * 64'(CLK_HZ)));
endpackage
`default_nettype wire

/* File: adao_sync.sv */
`default_nettype none
// two-flop synchroniser for a pin level
module adao_sync (
    input wire logic clk,   // system clock
    input wire logic reset, // synchronous reset
    input wire logic d,     // asynchronous level
    output logic q          // synchronised level
);
    logic meta;

    // meta is read by q only
    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: adao_rot_axis.sv */
`default_nettype none
// trapezoidal integration of one rate axis over a decimation window
module adao_rot_axis (
    input wire logic clk,          // system clock
    input wire logic reset,        // synchronous reset
    input wire logic sample,       // one-cycle sample pulse
    input wire logic first,        // sample opens a window
    input wire logic last,         // sample closes a window
    input wire logic [15:0] rate,  // rate sample, 0.02 deg/s lsb
    input wire logic [23:0] scale, // 1/(2 fs) in output units, 16 frac bits
    output logic [31:0] result     // saturated angle of last window
);
    logic signed [15:0] prev;
    logic signed [27:0] acc;
    logic signed [27:0] total;

    // each sample adds itself and its predecessor
    wire signed [27:0] pair = {{12{rate[15]}}, rate} + {{12{prev[15]}}, prev};
    wire signed [27:0] next_acc = (first ? 28'sh0 : acc) + pair;
    wire signed [52:0] prod = total * $signed({1'b0, scale});
    wire signed [36:0] scaled = prod[52:adao_pkg::SCALE_SHIFT];
    // a window too long for the range clips instead of wrapping
    wire ovf = (scaled[36:31] != 6'h00) && (scaled[36:31] != 6'h3f);

    always_ff @(posedge clk) begin
        if (reset) begin
            prev <= 16'sh0;
            acc <= 28'sh0;
            total <= 28'sh0;
        end else if (sample) begin
            prev <= rate;
            acc <= next_acc;
            if (last) begin
                total <= next_acc;
            end
        end
    end

    // divide by 2 fs through the scale factor, then clamp
    assign result = !ovf ? scaled[31:0] : (scaled[36] ? adao_pkg::ROT_NEG_FS : adao_pkg::ROT_POS_FS);
endmodule
`default_nettype wire

/* File: adao_outputs.sv */
`default_nettype none
// Behaviour
// - accel main word, two's complement, 0.8 mg
// - accel main words at 0x1e, 0x22, 0x26
// - accel main clamps to 0x57e4 and 0xa81c
// - accel fraction word extends main word downward
// - accel fraction words at 0x1c, 0x20, 0x24
// - delta angle is trapezoidal sum over 2 fs
// - window length is decimation setting plus one
// - internal sample clock rate is 2460 sps
// - angle main word spans 720 deg, saturates
// - angle fraction word joins main into 32 bits
// - angle fraction words x, z at 0x40, 0x48
// - main word upper, fraction word lower half
// - page selector reads zero after start-up
module adao_outputs #(
    parameter int INT_PERIOD = adao_pkg::INT_PERIOD_CYC // internal sample period in clocks
) (
    input wire logic clk,                       // 100 MHz system clock
    input wire logic reset,                     // synchronous, active high
    input wire logic [15:0] gyro_rate_x,        // x rate sample, 0.02 deg/s lsb
    input wire logic [15:0] gyro_rate_y,        // y rate sample
    input wire logic [15:0] gyro_rate_z,        // z rate sample
    input wire logic [31:0] accel_sample_x,     // x accel, 32-bit, main lsb 0.8 mg
    input wire logic [31:0] accel_sample_y,     // y accel
    input wire logic [31:0] accel_sample_z,     // z accel
    input wire logic ext_clk_sel,               // 1: external sample clock
    input wire logic ext_sample_clk,            // external sample clock pin
    input wire logic [10:0] decimation_setting, // window length minus one
    input wire logic page_wr,                   // write page selector
    input wire logic [15:0] page_wdata,         // new page selector value
    input wire logic rd_en,                     // read request pulse
    input wire logic [6:0] rd_addr,             // byte address in page
    output logic [15:0] rd_data,                // read data, registered
    output logic rd_valid,                      // read data valid pulse
    output logic [15:0] page_selector,          // active page
    output logic data_ready                     // new output words pulse
);
    logic [15:0] acc_main [3];
    logic [15:0] acc_frac [3];
    logic [15:0] rot_main [3];
    logic [15:0] rot_frac [3];
    logic [31:0] rot_result [3];
    logic [31:0] acc_clamped [3];
    logic [31:0] accel_in [3];
    logic [15:0] rate_in [3];
    logic [15:0] int_cnt;
    logic [15:0] per_cnt;
    logic [15:0] ext_period;
    logic [23:0] ext_scale;
    logic [10:0] dec_cnt;
    logic ext_s;
    logic ext_q;
    logic upd;

    assign accel_in[0] = accel_sample_x;
    assign accel_in[1] = accel_sample_y;
    assign accel_in[2] = accel_sample_z;
    assign rate_in[0] = gyro_rate_x;
    assign rate_in[1] = gyro_rate_y;
    assign rate_in[2] = gyro_rate_z;

    // the external clock is a pin, so it passes two flops first
    adao_sync u_ext_sync (
        .clk(clk),
        .reset(reset),
        .d(ext_sample_clk),
        .q(ext_s)
    );

    // sample pulse selection and window position
    wire int_tick = (int_cnt == 16'(INT_PERIOD - 1));
    wire ext_tick = ext_s & ~ext_q;
    wire sample = ext_clk_sel ? ext_tick : int_tick;
    wire first = (dec_cnt == 11'h000);
    wire last = (dec_cnt >= decimation_setting);
    wire [28:0] ext_prod = ext_period * adao_pkg::EXT_SCALE_PER_CYC;
    wire [23:0] scale = ext_clk_sel ? ext_scale : adao_pkg::SCALE_INT;

    // internal sample timer
    always_ff @(posedge clk) begin
        if (reset) begin
            int_cnt <= 16'h0000;
        end else begin
            int_cnt <= int_tick ? 16'h0000 : int_cnt + 16'h0001;
        end
    end

    // the external rate is measured as its period in clocks; beyond 65535
    // clocks the counter saturates, the measured period wraps to zero and the angles read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_q <= 1'b0;
            per_cnt <= 16'h0000;
            ext_period <= 16'(adao_pkg::EXT_MAX_PERIOD_CYC);
            ext_scale <= adao_pkg::SCALE_INT;
        end else begin
            ext_q <= ext_s;
            if (ext_tick) begin
                per_cnt <= 16'h0000;
                ext_period <= per_cnt + 16'h0001;
            end else if (per_cnt != 16'hffff) begin
                per_cnt <= per_cnt + 16'h0001;
            end
            ext_scale <= {3'h0, ext_prod[28:adao_pkg::EXT_FRAC]};
        end
    end

    // decimation window counter; a window closes after setting+1 samples
    always_ff @(posedge clk) begin
        if (reset) begin
            dec_cnt <= 11'h000;
            upd <= 1'b0;
            data_ready <= 1'b0;
        end else begin
            if (sample) begin
                dec_cnt <= last ? 11'h000 : dec_cnt + 11'h001;
            end
            upd <= sample & last;
            data_ready <= upd;
        end
    end

    // per-axis integration and accel clamping
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_axis
            adao_rot_axis u_rot (
                .clk(clk),
                .reset(reset),
                .sample(sample),
                .first(first),
                .last(last),
                .rate(rate_in[i]),
                .scale(scale),
                .result(rot_result[i])
            );

            // clip beyond +-18 g so the main word stays in range
            wire acc_hi = $signed(accel_in[i]) > $signed(adao_pkg::ACC_POS_FS);
            wire acc_lo = $signed(accel_in[i]) < $signed(adao_pkg::ACC_NEG_FS);
            assign acc_clamped[i] = acc_hi ? adao_pkg::ACC_POS_FS :
                                    acc_lo ? adao_pkg::ACC_NEG_FS : accel_in[i];

            // both halves of every axis latch on the same update pulse
            always_ff @(posedge clk) begin
                if (reset) begin
                    acc_main[i] <= adao_pkg::WORD_RESET;
                    acc_frac[i] <= adao_pkg::WORD_RESET;
                    rot_main[i] <= adao_pkg::WORD_RESET;
                    rot_frac[i] <= adao_pkg::WORD_RESET;
                end else if (upd) begin
                    acc_main[i] <= acc_clamped[i][31:16];
                    acc_frac[i] <= acc_clamped[i][15:0];
                    rot_main[i] <= rot_result[i][31:16];
                    rot_frac[i] <= rot_result[i][15:0];
                end
            end
        end
    endgenerate

    // page selector; other pages belong to other blocks and read zero here
    always_ff @(posedge clk) begin
        if (reset) begin
            page_selector <= adao_pkg::PAGE_RESET;
        end else if (page_wr) begin
            page_selector <= page_wdata;
        end
    end

    // read decode on the even byte address of each word
    wire [6:0] word_addr = {rd_addr[6:1], 1'b0};
    wire on_page = (page_selector == adao_pkg::OUTPUT_PAGE);
    wire [15:0] page_word =
        (word_addr == adao_pkg::OFS_ACC_X_FRAC) ? acc_frac[0] :
        (word_addr == adao_pkg::OFS_ACC_X_MAIN) ? acc_main[0] :
        (word_addr == adao_pkg::OFS_ACC_Y_FRAC) ? acc_frac[1] :
        (word_addr == adao_pkg::OFS_ACC_Y_MAIN) ? acc_main[1] :
        (word_addr == adao_pkg::OFS_ACC_Z_FRAC) ? acc_frac[2] :
        (word_addr == adao_pkg::OFS_ACC_Z_MAIN) ? acc_main[2] :
        (word_addr == adao_pkg::OFS_ROT_X_FRAC) ? rot_frac[0] :
        (word_addr == adao_pkg::OFS_ROT_X_MAIN) ? rot_main[0] :
        (word_addr == adao_pkg::OFS_ROT_Y_FRAC) ? rot_frac[1] :
        (word_addr == adao_pkg::OFS_ROT_Y_MAIN) ? rot_main[1] :
        (word_addr == adao_pkg::OFS_ROT_Z_FRAC) ? rot_frac[2] :
        (word_addr == adao_pkg::OFS_ROT_Z_MAIN) ? rot_main[2] : adao_pkg::WORD_RESET;
    wire [15:0] rd_word = (word_addr == adao_pkg::OFS_PAGE) ? page_selector :
                          on_page ? page_word : adao_pkg::WORD_RESET;

    // read data held until the next request
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= adao_pkg::WORD_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rd_word;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_close;
        sample && last;
    endsequence
    sequence s_publish;
        upd ##1 data_ready;
    endsequence

    a_page_after_reset: assert property (disable iff (1'b0) reset |=> page_selector == 16'h0000)
        else $error("page selector not zero after reset");
    a_acc_x_main_read: assert property (rd_en && on_page && !page_wr && rd_addr == 7'h1e
        |=> rd_valid && rd_data == $past(acc_main[0]))
        else $error("accel x main word read wrong");
    a_acc_z_frac_read: assert property (rd_en && on_page && !page_wr && rd_addr == 7'h24
        |=> rd_data == $past(acc_frac[2]))
        else $error("accel z fraction word read wrong");
    a_rot_y_main_read: assert property (rd_en && on_page && !page_wr && rd_addr == 7'h46
        |=> rd_data == $past(rot_main[1]))
        else $error("angle y main word read wrong");
    a_rot_fracs_read: assert property (rd_en && on_page && !page_wr &&
        (rd_addr == 7'h40 || rd_addr == 7'h44 || rd_addr == 7'h48)
        |=> rd_data == $past(rot_frac[rd_addr[3:2]]))
        else $error("angle fraction word read wrong");
    a_acc_in_range: assert property ($signed(acc_main[0]) <= 16'sh57e4 &&
        $signed(acc_main[0]) >= -16'sh57e4)
        else $error("accel main word out of range");
    a_window_wrap: assert property (s_close |=> dec_cnt == 11'h000 ##0 s_publish)
        else $error("window did not close and publish");
    a_window_step: assert property (sample && !last |=> dec_cnt == $past(dec_cnt) + 11'h001)
        else $error("window count did not advance");
    a_int_rate: assert property (!ext_clk_sel
        |-> scale == 24'(64'h0000_8000_0000_0000 / (64'd72000 * 64'd2460)))
        else $error("internal scale wrong");
    a_words_coherent: assert property (!upd |=> $stable(rot_main[0]) && $stable(rot_frac[0]) &&
        $stable(acc_main[0]) && $stable(acc_frac[0]))
        else $error("output word changed outside update");
    a_rot_latch: assert property (upd |=> {rot_main[2], rot_frac[2]} == $past(rot_result[2]))
        else $error("angle words do not form result");

    // the remaining words, each at its own address
    a_acc_x_frac_read: assert property (rd_en && on_page && rd_addr == 7'h1c
        |=> rd_data == $past(acc_frac[0]))
        else $error("accel x fraction word read wrong");
    a_acc_y_frac_read: assert property (rd_en && on_page && rd_addr == 7'h20
        |=> rd_data == $past(acc_frac[1]))
        else $error("accel y fraction word read wrong");
    a_acc_y_main_read: assert property (rd_en && on_page && rd_addr == 7'h22
        |=> rd_data == $past(acc_main[1]))
        else $error("accel y main word read wrong");
    a_acc_z_main_read: assert property (rd_en && on_page && rd_addr == 7'h26
        |=> rd_data == $past(acc_main[2]))
        else $error("accel z main word read wrong");
    a_rot_x_main_read: assert property (rd_en && on_page && rd_addr == 7'h42
        |=> rd_data == $past(rot_main[0]))
        else $error("angle x main word read wrong");
    a_rot_z_main_read: assert property (rd_en && on_page && rd_addr == 7'h4a
        |=> rd_data == $past(rot_main[2]))
        else $error("angle z main word read wrong");

    // every request is answered exactly once, one cycle later
    a_rd_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered one cycle later");
    a_rd_no_extra: assert property (!rd_en |=> !rd_valid)
        else $error("read valid without a request");
    // the selector reads on every page; other words hide when it is not zero
    a_page_read: assert property (rd_en && rd_addr[6:1] == 6'h00 |=> rd_data == $past(page_selector))
        else $error("page selector read wrong");
    a_rd_off_page: assert property (rd_en && !on_page && rd_addr[6:1] != 6'h00 |=> rd_data == 16'h0000)
        else $error("word visible outside the output page");
    a_page_write: assert property (page_wr |=> page_selector == $past(page_wdata))
        else $error("page selector write lost");

    // accel words pass through inside full scale and clip outside it
    a_acc_clip_hi: assert property (upd && $signed(accel_in[0]) > $signed(adao_pkg::ACC_POS_FS)
        |=> {acc_main[0], acc_frac[0]} == adao_pkg::ACC_POS_FS)
        else $error("accel x not clipped to positive full scale");
    a_acc_clip_lo: assert property (upd && $signed(accel_in[1]) < $signed(adao_pkg::ACC_NEG_FS)
        |=> {acc_main[1], acc_frac[1]} == adao_pkg::ACC_NEG_FS)
        else $error("accel y not clipped to negative full scale");
    a_acc_y_pass: assert property (upd && $signed(accel_in[1]) <= $signed(adao_pkg::ACC_POS_FS) &&
        $signed(accel_in[1]) >= $signed(adao_pkg::ACC_NEG_FS)
        |=> {acc_main[1], acc_frac[1]} == $past(accel_in[1]))
        else $error("accel y words differ from sample");
    a_rot_x_latch: assert property (upd |=> {rot_main[0], rot_frac[0]} == $past(rot_result[0]))
        else $error("angle x words do not form result");

    // sample timing: timer period, external period measure, one-cycle ready
    a_int_wrap: assert property (int_tick |=> int_cnt == 16'h0000)
        else $error("internal timer did not wrap");
    a_int_count: assert property (!int_tick |=> int_cnt == $past(int_cnt) + 16'h0001)
        else $error("internal timer did not count");
    a_ext_measure: assert property (ext_tick |=> ext_period == $past(per_cnt) + 16'h0001)
        else $error("external period not measured");
    a_dec_hold: assert property (!sample |=> $stable(dec_cnt))
        else $error("window count moved without a sample");
    a_ready_pulse: assert property (data_ready |=> !data_ready)
        else $error("data ready longer than one cycle");
endmodule
`default_nettype wire

/* File: adao_ext_src.sv */
`default_nettype none
// far-side sample clock source, free running; the bench may slow it down between cases
module adao_ext_src (
    input wire logic clk,           // system clock
    input wire logic [15:0] period, // edge spacing in system clocks
    output logic ext_sample_clk     // sample clock pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial ext_sample_clk = 1'b0;
    // high for the first half of each period; the bench keeps period far below 50000 clocks
    always @(posedge clk) begin
        cnt <= (cnt + 1 >= int'(period)) ? 0 : cnt + 1;
        ext_sample_clk <= (cnt < int'(period) / 2);
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 20;
    logic clk = 1'b0, reset = 1'b1, ext_clk_sel = 1'b0, ext_sample_clk, page_wr = 1'b0, rd_en = 1'b0;
    logic rd_valid, data_ready;
    logic [15:0] gyro_rate_x = 16'h0000, gyro_rate_y = 16'h0000, gyro_rate_z = 16'h0000;
    logic [15:0] page_wdata = 16'h0000, rd_data, page_selector, ext_period = 16'h0028;
    logic [31:0] accel_sample_x = 32'h0000_0000, accel_sample_y = 32'h0000_0000, accel_sample_z = 32'h0000_0000;
    logic [10:0] decimation_setting = 11'h000;
    logic [6:0] rd_addr = 7'h00;
    logic [15:0] exp_q[$];
    logic [6:0] adr_q[$];
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    always #5 clk = ~clk;

    adao_outputs #(.INT_PERIOD(PER)) uut (.clk(clk), .reset(reset), .gyro_rate_x(gyro_rate_x),
        .gyro_rate_y(gyro_rate_y), .gyro_rate_z(gyro_rate_z), .accel_sample_x(accel_sample_x),
        .accel_sample_y(accel_sample_y), .accel_sample_z(accel_sample_z), .ext_clk_sel(ext_clk_sel),
        .ext_sample_clk(ext_sample_clk), .decimation_setting(decimation_setting), .page_wr(page_wr),
        .page_wdata(page_wdata), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .page_selector(page_selector), .data_ready(data_ready));
    adao_ext_src src (.clk(clk), .period(ext_period), .ext_sample_clk(ext_sample_clk));

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one read: the expectation is queued when the request goes out
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge clk);
        #1 rd_en = 1'b1;
        rd_addr = a;
        adr_q.push_back(a);
        exp_q.push_back(e);
        @(posedge clk);
        #1 rd_en = 1'b0;
    endtask

    task automatic wr_page(input logic [15:0] v);
        @(posedge clk);
        #1 page_wr = 1'b1;
        page_wdata = v;
        @(posedge clk);
        #1 page_wr = 1'b0;
    endtask

    task automatic wait_ready(input int n);
        repeat (n) @(negedge clk iff data_ready === 1'b1);
    endtask

    // expected angle with a steady rate: every term is 2w, then scaled down by 16 bits
    function automatic logic [31:0] angle(input logic [15:0] w, input logic [10:0] dec, input longint scl);
        longint s;
        s = 2 * longint'($signed(w)) * (longint'(dec) + 1) * scl;
        return 32'(s >>> 16);
    endfunction

    // read side watcher: answers arrive in request order
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) check("unrequested rd_valid", 32'h0, 32'h1);
            else check($sformatf("rd_data at %h", adr_q.pop_front()),
                {16'h0, exp_q.pop_front()}, {16'h0, rd_data});
        end
    end

    // hang guard, well above the two to three thousand cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic run_case(input logic ext, input logic [10:0] dec, input longint scl);
        logic [15:0] w[3];
        logic [31:0] acc[3], ang;
        int t0;
        logic [6:0] am[3], af[3], rm[3], rf[3];
        am = '{adao_pkg::OFS_ACC_X_MAIN, adao_pkg::OFS_ACC_Y_MAIN, adao_pkg::OFS_ACC_Z_MAIN};
        af = '{adao_pkg::OFS_ACC_X_FRAC, adao_pkg::OFS_ACC_Y_FRAC, adao_pkg::OFS_ACC_Z_FRAC};
        rm = '{adao_pkg::OFS_ROT_X_MAIN, adao_pkg::OFS_ROT_Y_MAIN, adao_pkg::OFS_ROT_Z_MAIN};
        rf = '{adao_pkg::OFS_ROT_X_FRAC, adao_pkg::OFS_ROT_Y_FRAC, adao_pkg::OFS_ROT_Z_FRAC};
        for (int i = 0; i < 3; i++) begin
            w[i] = 16'($urandom_range(0, 8000) - 4000);
            acc[i] = {16'($urandom_range(0, 44998) - 22499), 16'($urandom)};
        end
        @(posedge clk);
        #1 ext_clk_sel = ext;
        decimation_setting = dec;
        {gyro_rate_x, gyro_rate_y, gyro_rate_z} = {w[0], w[1], w[2]};
        {accel_sample_x, accel_sample_y, accel_sample_z} = {acc[0], acc[1], acc[2]};
        // the first windows after a change mix old and new settings, so skip them
        wait_ready(3);
        t0 = cyc;
        wait_ready(1);
        if (!ext) check("window clocks", 32'((int'(dec) + 1) * PER), 32'(cyc - t0));
        for (int i = 0; i < 3; i++) begin
            ang = angle(w[i], dec, scl);
            rd(am[i], acc[i][31:16]);
            rd(af[i], acc[i][15:0]);
            rd(rm[i], ang[31:16]);
            rd(rf[i], ang[15:0]);
        end
    endtask

    initial begin
        void'($urandom(32'h7b35fac7));
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        rd(adao_pkg::OFS_PAGE, 16'h0000);
        rd(adao_pkg::OFS_ROT_Y_MAIN, 16'h0000);
        // another page hides the output words but still shows the selector
        wr_page(16'h0003);
        check("page_selector", 32'h0000_0003, {16'h0000, page_selector});
        rd(adao_pkg::OFS_PAGE, 16'h0003);
        rd(adao_pkg::OFS_ACC_X_MAIN, 16'h0000);
        wr_page(16'h0000);
        check("page_selector", 32'h0000_0000, {16'h0000, page_selector});
        rd(7'h02, 16'h0000);
        run_case(1'b0, 11'h000, longint'(adao_pkg::SCALE_INT));
        run_case(1'b0, 11'h003, longint'(adao_pkg::SCALE_INT));
        run_case(1'b0, 11'($urandom_range(1, 12)), longint'(adao_pkg::SCALE_INT));
        run_case(1'b1, 11'h003, (40 * longint'(adao_pkg::EXT_SCALE_PER_CYC)) >> adao_pkg::EXT_FRAC);
        ext_period = 16'h0064;
        run_case(1'b1, 11'h000, (100 * longint'(adao_pkg::EXT_SCALE_PER_CYC)) >> adao_pkg::EXT_FRAC);
        // out-of-range acceleration is clamped to full scale
        @(posedge clk);
        #1 ext_clk_sel = 1'b0;
        accel_sample_x = 32'h7fff_ffff;
        accel_sample_y = 32'h8000_0000;
        wait_ready(3);
        rd(adao_pkg::OFS_ACC_X_MAIN, 16'h57e4);
        rd(adao_pkg::OFS_ACC_X_FRAC, 16'h0000);
        rd(adao_pkg::OFS_ACC_Y_MAIN, 16'ha81c);
        rd(adao_pkg::OFS_ACC_Y_FRAC, 16'h0000);
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) check("answers missing", 32'h0, 32'(exp_q.size()));
        conclude();
    end
endmodule
`default_nettype wire
